// file: rtl/psw_detect.sv
// Threshold hysteresis and under-range decision
`timescale 1ns/1ps
module psw_detect
    import psw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    input  wire logic [15:0] prox_value,
    input  wire logic        prox_valid,
    input  wire logic        under_range,
    input  wire logic        temp_done,
    input  wire logic        ur_en,
    input  wire logic [15:0] hi_thr,
    input  wire logic [15:0] lo_thr,
    output logic             detect_r
);
    logic       temp_seen_r;
    logic [2:0] conv_cnt_r;
    logic       early;

    assign early = conv_cnt_r < EARLY_CONV;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            temp_seen_r <= 1'b0;
        end else if (ce && temp_done) begin
            temp_seen_r <= 1'b1;
        end
    end

    // Saturates; only "fewer than three done" matters
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_cnt_r <= 3'h0;
        end else if (ce && prox_valid && conv_cnt_r != CONV_SAT) begin
            conv_cnt_r <= conv_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            detect_r <= 1'b0;
        end else if (ce && prox_valid) begin
            if (under_range) begin
                if (temp_seen_r && (early || ur_en)) begin
                    detect_r <= 1'b1;
                end
            end else if (prox_value > hi_thr) begin
                detect_r <= 1'b1;
            end else if (prox_value < lo_thr) begin
                detect_r <= 1'b0;
            end
        end
    end

    property p_ur(logic c);
        @(posedge clk) disable iff (!reset_n)
        ce && prox_valid && under_range && c |=> detect_r;
    endproperty

    AST_HYST_HOLD: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && prox_valid && !under_range && prox_value <= hi_thr
        && prox_value >= lo_thr |=> $stable(detect_r))
        else $error("detect changed inside hysteresis band");
    AST_UR_NO_TEMP: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && prox_valid && under_range && !temp_seen_r |=> $stable(detect_r))
        else $error("under range acted before temperature");
    AST_UR_EARLY: assert property (p_ur(temp_seen_r && early))
        else $error("early under range did not switch");
    AST_UR_EN: assert property (p_ur(temp_seen_r && ur_en))
        else $error("enabled under range did not switch");
    AST_UR_LATE: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && prox_valid && under_range && !early && !ur_en
        |=> $stable(detect_r))
        else $error("late under range changed switch with enable off");
endmodule // psw_detect

// file: rtl/psw_pkg.sv
// Shared constants for the proximity switch output block
package psw_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int          CNT_W         = 22;

    localparam logic [7:0] ADDR_OUT_INIT = 8'h72;
    localparam logic [7:0] ADDR_HI_UP    = 8'h73;
    localparam logic [7:0] ADDR_HI_LO    = 8'h74;
    localparam logic [7:0] ADDR_LO_UP    = 8'h75;
    localparam logic [7:0] ADDR_LO_LO    = 8'h76;
    localparam logic [7:0] ADDR_OSC3     = 8'h77;
    localparam logic [7:0] ADDR_OUT_TAB  = 8'h78;

    localparam logic [7:0] OUT_SETUP_RESET = 8'h80;
    localparam logic [7:0] THRESH_RESET    = 8'h00;
    localparam logic [7:0] OSC3_RESET      = 8'h1B;
    localparam logic [7:0] OSC3_WR_MASK    = 8'h3F;
    localparam logic [7:0] READ_NONE       = 8'h00;

    localparam int OUT_DRV_HI  = 7;
    localparam int OUT_DRV_LO  = 6;
    localparam int OUT_TOPO    = 5;
    localparam int OUT_NC      = 4;
    localparam int OUT_LED_OFF = 3;
    localparam int OUT_LED_POL = 2;
    localparam int OUT_LED_CUR = 1;
    localparam int OUT_RATIO   = 0;
    localparam int OSC_UR_EN   = 5;
    localparam int OSCILLATION_AMPLITUDE_HI  = 4;
    localparam int OSCILLATION_AMPLITUDE_LO  = 3;
    localparam int OSC_RESP_HI = 2;
    localparam int OSC_RESP_LO = 0;

    localparam logic [1:0] AMP_1V   = 2'h0;
    localparam logic [1:0] AMP_2V   = 2'h1;
    localparam logic [1:0] AMP_4V   = 2'h2;
    localparam logic [1:0] AMP_RSVD = 2'h3;
    localparam logic [2:0] RESP_RSVD = 3'h0;
    localparam logic [2:0] RESP_384  = 3'h3;

    localparam logic [2:0] EARLY_CONV = 3'h3;
    localparam logic [2:0] CONV_SAT   = 3'h4;

    localparam int unsigned RETRY_ON_NS       = 30000;
    localparam int unsigned RETRY_OFF_SLOW_NS = 29970000;
    localparam int unsigned RETRY_OFF_FAST_NS = 3720000;
    localparam int unsigned RETRY_ON_CYC =
        (RETRY_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RETRY_OFF_SLOW_CYC =
        (RETRY_OFF_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RETRY_OFF_FAST_CYC =
        (RETRY_OFF_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    function automatic logic [15:0] join16(input logic [7:0] up,
                                           input logic [7:0] lo);
        return {up, lo};
    endfunction
endpackage

// file: rtl/psw_retry.sv
// Overload protection retry timer
`timescale 1ns/1ps
module psw_retry
    import psw_pkg::*;
#(
    parameter int unsigned OFF_SLOW_CYC = RETRY_OFF_SLOW_CYC,
    parameter int unsigned OFF_FAST_CYC = RETRY_OFF_FAST_CYC
)
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic ce,
    input  wire logic conduct_req,
    input  wire logic overload,
    input  wire logic ratio_fast,
    output logic      drive_allow,
    output logic      in_protect
);
    typedef enum logic [1:0] {PSW_NORMAL, PSW_REST, PSW_PROBE}
        psw_retry_state_t;
    psw_retry_state_t   state_r;
    logic [CNT_W-1:0]   cnt_r;
    logic [CNT_W-1:0]   off_last;

    localparam logic [CNT_W-1:0] ON_LAST = CNT_W'(RETRY_ON_CYC - 1);

    assign off_last = ratio_fast ? CNT_W'(OFF_FAST_CYC - 1)
                                 : CNT_W'(OFF_SLOW_CYC - 1);
    assign drive_allow = state_r != PSW_REST;
    assign in_protect  = state_r != PSW_NORMAL;

    // Compare with >= so a ratio change mid-rest cannot overrun
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= PSW_NORMAL;
            cnt_r   <= '0;
        end else if (ce) begin
            case (state_r)
                PSW_NORMAL: begin
                    cnt_r <= '0;
                    if (conduct_req && overload) begin
                        state_r <= PSW_REST;
                    end
                end
                PSW_REST: begin
                    if (cnt_r >= off_last) begin
                        state_r <= PSW_PROBE;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                PSW_PROBE: begin
                    if (cnt_r >= ON_LAST) begin
                        state_r <= overload ? PSW_REST : PSW_NORMAL;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                default: begin
                    state_r <= PSW_NORMAL;
                    cnt_r   <= '0;
                end
            endcase
        end
    end

    AST_PROBE_LEN: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && state_r == PSW_PROBE && cnt_r < ON_LAST |=> state_r == PSW_PROBE)
        else $error("probe ended early");
    AST_PROBE_FAIL: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && state_r == PSW_PROBE && cnt_r >= ON_LAST && overload
        |=> state_r == PSW_REST && !drive_allow)
        else $error("overload persisted but no rest");
endmodule // psw_retry

// file: rtl/psw_top.sv
// Proximity switch output decision and setup registers
`timescale 1ns/1ps
module psw_top
    import psw_pkg::*;
#(
    parameter int unsigned OFF_SLOW_CYC = RETRY_OFF_SLOW_CYC,
    parameter int unsigned OFF_FAST_CYC = RETRY_OFF_FAST_CYC
)
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_we,
    input  wire logic        reg_re,
    output logic [7:0]       reg_rdata,
    output logic             reg_rvalid,
    input  wire logic [15:0] prox_value,
    input  wire logic        prox_valid,
    input  wire logic        under_range,
    input  wire logic        temp_done,
    input  wire logic        overload,
    output logic             transistor_drive_pin,
    output logic [1:0]       transistor_drive_strength,
    output logic             output_topology_pnp,
    output logic             indicator_led,
    output logic             indicator_strength,
    output logic [1:0]       oscillation_amplitude,
    output logic [2:0]       filter_response,
    output logic             overload_protect
);
    logic [7:0]  out_init_r;
    logic [7:0]  hi_up_r;
    logic [7:0]  hi_lo_r;
    logic [7:0]  lo_up_r;
    logic [7:0]  lo_lo_r;
    logic [7:0]  osc3_r;
    logic [7:0]  out_tab_r;
    logic [7:0]  rdata_r;
    logic        rvalid_r;
    logic        drive_r;
    logic [1:0]  strength_r;
    logic        topo_r;
    logic        led_r;
    logic        led_cur_r;
    logic [1:0]  amp_r;
    logic [2:0]  resp_r;
    logic        protect_r;
    logic [7:0]  rdata_nxt;
    logic [15:0] hi_thr;
    logic [15:0] lo_thr;
    logic        det_state;
    logic        conduct;
    logic        drive_allow;
    logic        in_protect;
    logic        wr;

    assign wr     = ce && reg_we;
    assign hi_thr = join16(hi_up_r, hi_lo_r);
    assign lo_thr = join16(lo_up_r, lo_lo_r);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_init_r <= OUT_SETUP_RESET;
            out_tab_r  <= OUT_SETUP_RESET;
        end else if (wr && reg_addr == ADDR_OUT_INIT) begin
            out_init_r <= reg_wdata;
        end else if (wr && reg_addr == ADDR_OUT_TAB) begin
            out_tab_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hi_up_r <= THRESH_RESET;
            hi_lo_r <= THRESH_RESET;
        end else if (wr && reg_addr == ADDR_HI_UP) begin
            hi_up_r <= reg_wdata;
        end else if (wr && reg_addr == ADDR_HI_LO) begin
            hi_lo_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lo_up_r <= THRESH_RESET;
            lo_lo_r <= THRESH_RESET;
        end else if (wr && reg_addr == ADDR_LO_UP) begin
            lo_up_r <= reg_wdata;
        end else if (wr && reg_addr == ADDR_LO_LO) begin
            lo_lo_r <= reg_wdata;
        end
    end

    // Reserved top bits never stored, so they read back zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            osc3_r <= OSC3_RESET;
        end else if (wr && reg_addr == ADDR_OSC3) begin
            osc3_r <= reg_wdata & OSC3_WR_MASK;
        end
    end

    always_comb begin
        case (reg_addr)
            ADDR_OUT_INIT: rdata_nxt = out_init_r;
            ADDR_HI_UP:    rdata_nxt = hi_up_r;
            ADDR_HI_LO:    rdata_nxt = hi_lo_r;
            ADDR_LO_UP:    rdata_nxt = lo_up_r;
            ADDR_LO_LO:    rdata_nxt = lo_lo_r;
            ADDR_OSC3:     rdata_nxt = osc3_r;
            ADDR_OUT_TAB:  rdata_nxt = out_tab_r;
            default:       rdata_nxt = READ_NONE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r  <= READ_NONE;
            rvalid_r <= 1'b0;
        end else if (ce) begin
            rvalid_r <= reg_re;
            if (reg_re) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    psw_detect u_detect (
        .clk         (clk),
        .reset_n     (reset_n),
        .ce          (ce),
        .prox_value  (prox_value),
        .prox_valid  (prox_valid),
        .under_range (under_range),
        .temp_done   (temp_done),
        .ur_en       (osc3_r[OSC_UR_EN]),
        .hi_thr      (hi_thr),
        .lo_thr      (lo_thr),
        .detect_r    (det_state)
    );

    // Conduct flips with the normally-closed option
    assign conduct = det_state ^ out_tab_r[OUT_NC];

    psw_retry #(
        .OFF_SLOW_CYC (OFF_SLOW_CYC),
        .OFF_FAST_CYC (OFF_FAST_CYC)
    ) u_retry (
        .clk         (clk),
        .reset_n     (reset_n),
        .ce          (ce),
        .conduct_req (conduct),
        .overload    (overload),
        .ratio_fast  (out_tab_r[OUT_RATIO]),
        .drive_allow (drive_allow),
        .in_protect  (in_protect)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            drive_r   <= 1'b0;
            protect_r <= 1'b0;
        end else if (ce) begin
            drive_r   <= conduct && drive_allow;
            protect_r <= in_protect;
        end
    end

    // LED follows detection, not drive, so protection keeps it honest
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            led_r <= 1'b0;
        end else if (ce) begin
            led_r <= !out_tab_r[OUT_LED_OFF]
                     && (det_state ^ out_tab_r[OUT_LED_POL]);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strength_r <= OUT_SETUP_RESET[OUT_DRV_HI:OUT_DRV_LO];
            topo_r     <= OUT_SETUP_RESET[OUT_TOPO];
            led_cur_r  <= OUT_SETUP_RESET[OUT_LED_CUR];
            amp_r      <= AMP_RSVD;
            resp_r     <= RESP_384;
        end else if (ce) begin
            strength_r <= out_tab_r[OUT_DRV_HI:OUT_DRV_LO];
            topo_r     <= out_tab_r[OUT_TOPO];
            led_cur_r  <= out_tab_r[OUT_LED_CUR];
            amp_r      <= osc3_r[OSCILLATION_AMPLITUDE_HI:OSCILLATION_AMPLITUDE_LO];
            resp_r     <= osc3_r[OSC_RESP_HI:OSC_RESP_LO];
        end
    end

    assign reg_rdata                 = rdata_r;
    assign reg_rvalid                = rvalid_r;
    assign transistor_drive_pin      = drive_r;
    assign transistor_drive_strength = strength_r;
    assign output_topology_pnp       = topo_r;
    assign indicator_led             = led_r;
    assign indicator_strength        = led_cur_r;
    assign oscillation_amplitude     = amp_r;
    assign filter_response           = resp_r;
    assign overload_protect          = protect_r;

    sequence s_wr(logic [7:0] a);
        ce && reg_we && reg_addr == a ##1 ce;
    endsequence

    // Trip takes two edges: state first, then the output flops
    sequence s_trip;
        ce && !in_protect && conduct && overload ##1 ce;
    endsequence

    AST_NO_FAR: assert property (@(posedge clk) disable iff (!reset_n)
        ce && !out_tab_r[OUT_NC] && !det_state |=> !transistor_drive_pin)
        else $error("normally open drive conducts while far");
    AST_NC_NEAR: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && out_tab_r[OUT_NC] && det_state |=> !transistor_drive_pin)
        else $error("normally closed drive conducts while near");
    AST_NC_FAR: assert property (@(posedge clk) disable iff (!reset_n)
        ce && out_tab_r[OUT_NC] && !det_state && !in_protect
        |=> transistor_drive_pin)
        else $error("normally closed drive off while far");
    AST_LED_OFF: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && out_tab_r[OUT_LED_OFF] |=> !indicator_led)
        else $error("disabled indicator lit");
    AST_LED_NOFF: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && !out_tab_r[OUT_LED_OFF] && !out_tab_r[OUT_LED_POL]
        |=> indicator_led == $past(det_state))
        else $error("normally off indicator wrong");
    AST_LED_NON: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && !out_tab_r[OUT_LED_OFF] && out_tab_r[OUT_LED_POL]
        |=> indicator_led != $past(det_state))
        else $error("normally on indicator wrong");
    AST_HI_WR: assert property (@(posedge clk) disable iff (!reset_n)
        s_wr(ADDR_HI_UP) |-> hi_thr[15:8] == $past(reg_wdata))
        else $error("high threshold upper byte not stored");
    AST_LO_WR: assert property (@(posedge clk) disable iff (!reset_n)
        s_wr(ADDR_LO_LO) |-> lo_thr[7:0] == $past(reg_wdata))
        else $error("low threshold lower byte not stored");
    AST_AMP: assert property (@(posedge clk) disable iff (!reset_n)
        s_wr(ADDR_OSC3) |=> oscillation_amplitude == $past(reg_wdata[4:3], 2))
        else $error("amplitude field not applied");
    AST_TAB_OUT: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_wr(ADDR_OUT_TAB) |=> transistor_drive_strength
        == $past(reg_wdata[7:6], 2) && output_topology_pnp
        == $past(reg_wdata[5], 2) && indicator_strength
        == $past(reg_wdata[1], 2))
        else $error("output setup not applied");
    AST_NO_NEAR: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && !out_tab_r[OUT_NC] && det_state && !in_protect
        |=> transistor_drive_pin)
        else $error("normally open drive off while near");
    AST_TRIP: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_trip |=> !transistor_drive_pin && overload_protect)
        else $error("overload did not trip protection");
    AST_IN_REST: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && in_protect && !drive_allow |=> !transistor_drive_pin)
        else $error("drive on during protection rest");
    AST_HI_LO_WR: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_wr(ADDR_HI_LO) |-> hi_thr[7:0] == $past(reg_wdata))
        else $error("high threshold lower byte not stored");
    AST_LO_UP_WR: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_wr(ADDR_LO_UP) |-> lo_thr[15:8] == $past(reg_wdata))
        else $error("low threshold upper byte not stored");
    AST_RESP: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_wr(ADDR_OSC3) |=> filter_response == $past(reg_wdata[2:0], 2))
        else $error("response field not applied");
    AST_UR_EN_WR: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_wr(ADDR_OSC3) |-> osc3_r[OSC_UR_EN] == $past(reg_wdata[5]))
        else $error("under range enable not stored");
endmodule // psw_top

// file: sim/proximity_switch_output_config_tb_top.sv
// Self-checking bench for the proximity switch output block
`timescale 1ns/1ps
module proximity_switch_output_config_tb_top;
    import psw_pkg::*;
    localparam int SLOW = 50;
    localparam int FAST = 20;
    logic        clk, reset_n, ce, reg_we, reg_re, rvalid;
    logic [7:0]  reg_addr, reg_wdata, rdata;
    logic [15:0] prox_value;
    logic        prox_valid, under_range, temp_done, short_on;
    logic        pin, pnp, led, lstr, prot, overload;
    logic [1:0]  dstr, amp;
    logic [2:0]  resp;
    int          miscompares, checks_done, n;

    psw_top #(.OFF_SLOW_CYC(SLOW), .OFF_FAST_CYC(FAST)) u_psw_top (
        .clk(clk), .reset_n(reset_n), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(rdata), .reg_rvalid(rvalid), .prox_value(prox_value),
        .prox_valid(prox_valid), .under_range(under_range),
        .temp_done(temp_done), .overload(overload),
        .transistor_drive_pin(pin), .transistor_drive_strength(dstr),
        .output_topology_pnp(pnp), .indicator_led(led),
        .indicator_strength(lstr), .oscillation_amplitude(amp),
        .filter_response(resp), .overload_protect(prot));

    psw_load_model u_psw_load_model (.clk(clk), .reset_n(reset_n),
        .drive_on(pin), .short_on(short_on), .overload(overload));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check8(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_cnt(input string what, input int lo, input int hi,
                             input int got);
        checks_done++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("wrong value %s expected %0d..%0d seen %0d", what,
                     lo, hi, got);
        end
    endtask

    task automatic do_reset();
        reset_n = 1'b0;
        repeat (10) @(posedge clk);
        #1 reset_n = 1'b1;
        @(posedge clk);
        #1;
    endtask

    // Strobe dropped a cycle early so back-to-back calls never overlap
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_we = 1'b1;
        @(posedge clk);
        #1 reg_we = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_re = 1'b1;
        @(posedge clk);
        #1 reg_re = 1'b0;
        check8("read valid", 8'h01, {7'h00, rvalid});
        check8("read data", exp, rdata);
        @(posedge clk);
        #1;
    endtask

    // One conversion; outputs settle two edges after the strobe
    task automatic conv(input logic [15:0] v, input logic ur);
        prox_value = v;
        under_range = ur;
        prox_valid = 1'b1;
        @(posedge clk);
        #1 prox_valid = 1'b0;
        under_range = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic count_while(input logic lvl, output int cnt);
        cnt = 0;
        while (pin === lvl && cnt < 5000) begin
            @(posedge clk);
            #1 cnt++;
        end
    endtask

    task automatic t_reset_regs();
        logic [7:0] exp [8];
        exp = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1B, 8'h80, 8'h00};
        check8("drive strength", 8'h02, {6'h00, dstr});
        check8("amplitude", 8'h03, {6'h00, amp});
        check8("response", 8'h03, {5'h00, resp});
        for (int i = 0; i < 8; i++) begin
            rd(ADDR_OUT_INIT + 8'(i), exp[i]);
        end
        ce = 1'b0;
        wr(ADDR_HI_UP, 8'hFF);
        ce = 1'b1;
        rd(ADDR_HI_UP, 8'h00);
        wr(ADDR_OSC3, 8'hD2);
        rd(ADDR_OSC3, 8'h12);
        check8("amplitude", 8'h02, {6'h00, amp});
        check8("response", 8'h02, {5'h00, resp});
        wr(ADDR_OSC3, 8'h03);
        check8("amplitude", 8'h00, {6'h00, amp});
        $display("test reset_regs done");
    endtask

    task automatic t_out_table();
        logic [7:0] cfg [3];
        cfg = '{8'h63, 8'hC0, 8'h9E};
        wr(ADDR_OUT_INIT, 8'h55);
        rd(ADDR_OUT_INIT, 8'h55);
        foreach (cfg[i]) begin
            wr(ADDR_OUT_TAB, cfg[i]);
            check8("drive strength", 8'(cfg[i][7:6]), 8'(dstr));
            check8("topology", {7'h00, cfg[i][5]}, {7'h00, pnp});
            check8("led strength", {7'h00, cfg[i][1]}, {7'h00, lstr});
        end
        $display("test out_table done");
    endtask

    task automatic t_detect();
        logic [7:0] cfg [4];
        cfg = '{8'h00, 8'h10, 8'h04, 8'h08};
        wr(ADDR_HI_UP, 8'h80);
        wr(ADDR_HI_LO, 8'h00);
        wr(ADDR_LO_UP, 8'h40);
        wr(ADDR_LO_LO, 8'h00);
        foreach (cfg[i]) begin
            wr(ADDR_OUT_TAB, cfg[i]);
            conv(16'h3000, 1'b0);
            check8("pin far", {7'h00, cfg[i][4]}, {7'h00, pin});
            check8("led far", 8'(!cfg[i][3] & cfg[i][2]),
                   {7'h00, led});
            conv(16'h9000, 1'b0);
            check8("pin near", {7'h00, !cfg[i][4]}, {7'h00, pin});
            check8("led near", 8'(!cfg[i][3] & !cfg[i][2]),
                   {7'h00, led});
        end
        wr(ADDR_OUT_TAB, 8'h00);
        conv(16'h6000, 1'b0);
        check8("pin hold high", 8'h01, {7'h00, pin});
        conv(16'h3000, 1'b0);
        conv(16'h8000, 1'b0);
        check8("pin at high edge", 8'h00, {7'h00, pin});
        conv(16'h9000, 1'b0);
        conv(16'h4000, 1'b0);
        check8("pin at low edge", 8'h01, {7'h00, pin});
        $display("test detect done");
    endtask

    task automatic t_under_range();
        do_reset();
        wr(ADDR_LO_LO, 8'h10);
        conv(16'h0000, 1'b1);
        check8("no temp", 8'h00, {7'h00, pin});
        temp_done = 1'b1;
        @(posedge clk);
        #1 temp_done = 1'b0;
        conv(16'h0000, 1'b1);
        check8("early under range", 8'h01, {7'h00, pin});
        conv(16'h0000, 1'b0);
        conv(16'h0000, 1'b1);
        check8("late disabled", 8'h00, {7'h00, pin});
        wr(ADDR_OSC3, 8'h3B);
        conv(16'h0000, 1'b1);
        check8("late enabled", 8'h01, {7'h00, pin});
        $display("test under_range done");
    endtask

    task automatic t_overload();
        short_on = 1'b1;
        count_while(1'b1, n);
        check8("protect", 8'h01, {7'h00, prot});
        count_while(1'b0, n);
        check_cnt("slow rest", SLOW - 2, SLOW + 4, n);
        wr(ADDR_OUT_TAB, 8'h81);
        count_while(1'b1, n);
        check_cnt("probe", 2995, 3000, n + 2);
        count_while(1'b0, n);
        check_cnt("fast rest", FAST - 2, FAST + 4, n);
        short_on = 1'b0;
        repeat (3010) @(posedge clk);
        #1;
        check8("protect left", 8'h00, {7'h00, prot});
        check8("pin back", 8'h01, {7'h00, pin});
        $display("test overload done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // About 6.2k cycles expected; three times that means a hang
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("watchdog expired");
        final_report();
    end

    initial begin
        miscompares = 0;
        checks_done = 0;
        ce = 1'b1;
        {reg_we, reg_re, prox_valid, under_range} = 4'h0;
        {temp_done, short_on} = 2'h0;
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        prox_value = 16'h0000;
        @(posedge clk);
        #1 do_reset();
        t_reset_regs();
        t_out_table();
        t_detect();
        t_under_range();
        t_overload();
        final_report();
    end
endmodule // proximity_switch_output_config_tb_top

// file: sim/psw_load_model.sv
// Load model: switching transistor with a shortable load
`timescale 1ns/1ps
module psw_load_model (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic drive_on,
    input  wire logic short_on,
    output logic      overload
);
    // Registered sense, a real load trips only after conduction
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overload <= 1'b0;
        end else begin
            overload <= drive_on & short_on;
        end
    end
endmodule // psw_load_model
